// ### hdl/tbg_timer_end.sv
// Third timer with baud generator, capture and auto-reload, feeding the serial port bit clocks.
//
// What this block does
// - tx_clock_select picks first timer or this timer.
// - rx_clock_select picks receive source independently.
// - Baud mode rollover reloads counter from reload pair.
// - Bit clock is overflow rate over sixteen.
// - Count oscillator/2 in baud, /12 otherwise.
// - Internal bit rate is osc/(32*(65536-reload)).
// - Baud mode only when either select is set.
// - Baud rollover sets no flag, no interrupt.
// - Baud trigger edge sets flag, never reloads.
// - Baud mode may count external pin edges.
// - Software avoids counter access during baud mode.
// - Software may read, not write, reload then.
// - Software stops the timer before register access.
// - Timer setup codes per mode listed.
// - Counter setup codes per mode listed.
// - Run bit set separately except baud codes.
// - Trigger edge reloads or captures outside baud.
// - Counter select chooses osc/12 (osc/2 in baud) or pin falls.
// - Enabled interrupt follows either flag.
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module tbg_timer_end
	import tbg_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	tbg_link_if.dev   link,
	input  wire logic external_count_pin_in,
	input  wire logic trigger_input_pin_in,
	input  wire logic timer1_overflow_in,
	output logic      overflow_pulse_out,
	output logic      tx_bit_clock_out,
	output logic      rx_bit_clock_out,
	output logic      timer_irq_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Sixteen-step divider shared by both serial directions.
	function automatic logic [3:0] div16_next(input logic [3:0] cur, input logic step);
		div16_next = step ? cur + 4'h1 : cur;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [2:0]  cnt_sync_q;
	logic [2:0]  trg_sync_q;
	logic        cnt_lvl_q;
	logic        trg_lvl_q;
	logic        cnt_lvl_d;
	logic        trg_lvl_d;
	logic        cnt_fall;
	logic        trg_fall;
	logic        cnt_agree;
	logic        trg_agree;

	logic        div2_q;
	logic [3:0]  div12_q;
	logic [3:0]  div12_d;

	logic [7:0]  ctrl_q;
	logic [7:0]  ctrl_d;
	logic [7:0]  ctrl_base;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic [15:0] reload_q;
	logic [15:0] reload_d;

	logic        baud_mode;
	logic        capture_mode;
	logic        int_tick;
	logic        count_tick;
	logic        rollover;
	logic        ext_edge;
	logic        ext_reload;
	logic        ext_capture;
	logic        load_reload;
	logic        tf_set;
	logic        exf_set;

	logic        overflow_q;
	logic        tx_src;
	logic        rx_src;
	logic [3:0]  tx_div_q;
	logic [3:0]  rx_div_q;
	logic        tx_bit_q;
	logic        rx_bit_q;
	logic        irq_q;

	// ----------------------------------------------------------------
	// Pin filters
	// ----------------------------------------------------------------
	// A pin change is believed only once the second and third stages agree,
	// so a single metastable sample cannot produce a false edge.
	assign cnt_agree = (cnt_sync_q[1] == cnt_sync_q[2]);
	assign trg_agree = (trg_sync_q[1] == trg_sync_q[2]);
	assign cnt_lvl_d = cnt_agree ? cnt_sync_q[2] : cnt_lvl_q;
	assign trg_lvl_d = trg_agree ? trg_sync_q[2] : trg_lvl_q;
	assign cnt_fall  = cnt_lvl_q & cnt_agree & ~cnt_sync_q[2];
	assign trg_fall  = trg_lvl_q & trg_agree & ~trg_sync_q[2];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_sync_q <= 3'h7;
			trg_sync_q <= 3'h7;
			cnt_lvl_q  <= 1'b1;
			trg_lvl_q  <= 1'b1;
		end else begin
			cnt_sync_q <= {cnt_sync_q[1:0], external_count_pin_in};
			trg_sync_q <= {trg_sync_q[1:0], trigger_input_pin_in};
			cnt_lvl_q  <= cnt_lvl_d;
			trg_lvl_q  <= trg_lvl_d;
		end
	end

	// ----------------------------------------------------------------
	// Mode decode and count tick
	// ----------------------------------------------------------------
	assign baud_mode    = ctrl_q[CTL_TX_CLOCK_SELECT] | ctrl_q[CTL_RX_CLOCK_SELECT];
	assign capture_mode = ~baud_mode & ctrl_q[CTL_CAPTURE_RELOAD];
	assign div12_d      = (div12_q == MACHINE_CYCLE_LAST) ? 4'h0 : div12_q + 4'h1;
	// The prescalers run free, so the first tick after run is set may come
	// up to one prescale period late.
	assign int_tick     = baud_mode ? div2_q : (div12_q == MACHINE_CYCLE_LAST);
	assign count_tick   = ctrl_q[CTL_RUN_CONTROL]
		& (ctrl_q[CTL_TIMER_COUNTER] ? cnt_fall : int_tick);

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			div2_q  <= 1'b0;
			div12_q <= 4'h0;
		end else begin
			div2_q  <= ~div2_q;
			div12_q <= div12_d;
		end
	end

	// ----------------------------------------------------------------
	// Counter, reload and capture
	// ----------------------------------------------------------------
	assign rollover    = count_tick & (count_q == COUNT_ALL_ONES);
	assign ext_edge    = ctrl_q[CTL_EXT_EDGE_ENABLE] & trg_fall;
	assign ext_reload  = ext_edge & ~baud_mode & ~capture_mode;
	assign ext_capture = ext_edge & capture_mode;
	assign load_reload = (rollover & ~capture_mode) | ext_reload;

	// A software write wins over counting; software is expected to stop the
	// timer first, so the collision only costs one tick.
	always_comb begin
		if (link.count_wr) begin
			count_d = link.count_wdata;
		end else if (load_reload) begin
			count_d = reload_q;
		end else if (count_tick) begin
			count_d = count_q + 16'h0001;
		end else begin
			count_d = count_q;
		end
	end

	// A capture beats a software reload write in the same cycle.
	assign reload_d = ext_capture ? count_q : (link.reload_wr ? link.reload_wdata : reload_q);

	// ----------------------------------------------------------------
	// Control register and flags
	// ----------------------------------------------------------------
	assign tf_set    = rollover & ~baud_mode;
	assign exf_set   = ext_edge;
	assign ctrl_base = link.ctrl_wr ? link.ctrl_wdata : ctrl_q;

	// Hardware setting a flag wins over a software clear in the same cycle.
	always_comb begin
		ctrl_d                    = ctrl_base;
		ctrl_d[CTL_OVERFLOW_FLAG] = ctrl_base[CTL_OVERFLOW_FLAG] | tf_set;
		ctrl_d[CTL_EXT_EDGE_FLAG] = ctrl_base[CTL_EXT_EDGE_FLAG] | exf_set;
	end

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_q   <= CTRL_RESET;
			count_q  <= COUNT_RESET;
			reload_q <= RELOAD_RESET;
			irq_q    <= 1'b0;
		end else begin
			ctrl_q   <= ctrl_d;
			count_q  <= count_d;
			reload_q <= reload_d;
			irq_q    <= link.irq_enable & (ctrl_d[CTL_OVERFLOW_FLAG] | ctrl_d[CTL_EXT_EDGE_FLAG]);
		end
	end

	// ----------------------------------------------------------------
	// Serial bit clocks
	// ----------------------------------------------------------------
	// The overflow pulse is only routed to a direction whose select is set.
	assign tx_src = ctrl_q[CTL_TX_CLOCK_SELECT] ? overflow_q : timer1_overflow_in;
	assign rx_src = ctrl_q[CTL_RX_CLOCK_SELECT] ? overflow_q : timer1_overflow_in;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			overflow_q <= 1'b0;
			tx_div_q   <= 4'h0;
			rx_div_q   <= 4'h0;
			tx_bit_q   <= 1'b0;
			rx_bit_q   <= 1'b0;
		end else begin
			overflow_q <= rollover & baud_mode;
			tx_div_q   <= div16_next(tx_div_q, tx_src);
			rx_div_q   <= div16_next(rx_div_q, rx_src);
			tx_bit_q   <= tx_src & (tx_div_q == BIT_DIVIDE_LAST);
			rx_bit_q   <= rx_src & (rx_div_q == BIT_DIVIDE_LAST);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign overflow_pulse_out = overflow_q;
	assign tx_bit_clock_out   = tx_bit_q;
	assign rx_bit_clock_out   = rx_bit_q;
	assign timer_irq_out      = irq_q;
	assign link.ctrl_rdata    = ctrl_q;
	assign link.reload_rdata  = reload_q;
	assign link.count_rdata   = count_q;

endmodule

// ### hdl/tbg_pkg.sv
// Constants shared by the timer end and the register end of the baud generator.
package tbg_pkg;

	// ----------------------------------------------------------------
	// Timer control register bit positions
	// ----------------------------------------------------------------
	localparam int unsigned CTL_OVERFLOW_FLAG   = 7;
	localparam int unsigned CTL_EXT_EDGE_FLAG   = 6;
	localparam int unsigned CTL_RX_CLOCK_SELECT = 5;
	localparam int unsigned CTL_TX_CLOCK_SELECT = 4;
	localparam int unsigned CTL_EXT_EDGE_ENABLE = 3;
	localparam int unsigned CTL_RUN_CONTROL     = 2;
	localparam int unsigned CTL_TIMER_COUNTER   = 1;
	localparam int unsigned CTL_CAPTURE_RELOAD  = 0;

	// ----------------------------------------------------------------
	// Reset values and the all-ones rollover count
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] COUNT_RESET  = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

	// ----------------------------------------------------------------
	// Setup codes for the control register
	// ----------------------------------------------------------------
	localparam logic [7:0] SETUP_RELOAD_INT    = 8'h00;
	localparam logic [7:0] SETUP_RELOAD_EXT    = 8'h08;
	localparam logic [7:0] SETUP_CAPTURE_INT   = 8'h01;
	localparam logic [7:0] SETUP_CAPTURE_EXT   = 8'h09;
	localparam logic [7:0] SETUP_BAUD_BOTH_INT = 8'h34;
	localparam logic [7:0] SETUP_BAUD_BOTH_EXT = 8'h36;
	localparam logic [7:0] SETUP_BAUD_RX_INT   = 8'h24;
	localparam logic [7:0] SETUP_BAUD_RX_EXT   = 8'h26;
	localparam logic [7:0] SETUP_BAUD_TX_INT   = 8'h14;
	localparam logic [7:0] SETUP_BAUD_TX_EXT   = 8'h16;
	localparam logic [7:0] SETUP_CNT_RELOAD_INT  = 8'h02;
	localparam logic [7:0] SETUP_CNT_RELOAD_EXT  = 8'h0a;
	localparam logic [7:0] SETUP_CNT_CAPTURE_INT = 8'h03;
	localparam logic [7:0] SETUP_CNT_CAPTURE_EXT = 8'h0b;

	// ----------------------------------------------------------------
	// Prescaler and serial divider counts
	// ----------------------------------------------------------------
	localparam logic [3:0] MACHINE_CYCLE_LAST = 4'hb;
	localparam logic [3:0] BIT_DIVIDE_LAST    = 4'hf;

	// ----------------------------------------------------------------
	// APB register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CONTROL    = 8'h00;
	localparam logic [7:0] OFS_RELOAD     = 8'h04;
	localparam logic [7:0] OFS_COUNT      = 8'h08;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0c;

endpackage

// ### hdl/tbg_link_if.sv
// Interface joining the timer end and its register end.
`timescale 1ns/10ps
interface tbg_link_if;
	logic        ctrl_wr;
	logic [7:0]  ctrl_wdata;
	logic        reload_wr;
	logic [15:0] reload_wdata;
	logic        count_wr;
	logic [15:0] count_wdata;
	logic        irq_enable;
	logic [7:0]  ctrl_rdata;
	logic [15:0] reload_rdata;
	logic [15:0] count_rdata;

	modport dev (
		input  ctrl_wr, ctrl_wdata, reload_wr, reload_wdata, count_wr, count_wdata, irq_enable,
		output ctrl_rdata, reload_rdata, count_rdata
	);

	modport host (
		output ctrl_wr, ctrl_wdata, reload_wr, reload_wdata, count_wr, count_wdata, irq_enable,
		input  ctrl_rdata, reload_rdata, count_rdata
	);
endinterface

// ### hdl/tbg_apb_end.sv
// APB register end that lets software set up and observe the baud generator timer.
`timescale 1ns/10ps
module tbg_apb_end
	import tbg_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	tbg_link_if.host         link
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic        setup_phase;
	logic        access_phase;
	logic        hit_ctrl;
	logic        hit_reload;
	logic        hit_count;
	logic        hit_irq_en;
	logic        mapped;
	logic        wr_access;
	logic [31:0] rd_mux;
	logic [31:0] prdata_q;
	logic        irq_en_q;

	assign setup_phase  = psel_in & ~penable_in;
	assign access_phase = psel_in & penable_in;
	assign hit_ctrl     = (paddr_in == OFS_CONTROL);
	assign hit_reload   = (paddr_in == OFS_RELOAD);
	assign hit_count    = (paddr_in == OFS_COUNT);
	assign hit_irq_en   = (paddr_in == OFS_IRQ_ENABLE);
	assign mapped       = hit_ctrl | hit_reload | hit_count | hit_irq_en;
	assign wr_access    = access_phase & pwrite_in & mapped;

	// ----------------------------------------------------------------
	// Write strobes towards the timer
	// ----------------------------------------------------------------
	// Writes reach the timer on the access edge; software should clear the
	// run bit before touching count or reload, as a write can meet a reload.
	assign link.ctrl_wr      = wr_access & hit_ctrl;
	assign link.ctrl_wdata   = pwdata_in[7:0];
	assign link.reload_wr    = wr_access & hit_reload;
	assign link.reload_wdata = pwdata_in[15:0];
	assign link.count_wr     = wr_access & hit_count;
	assign link.count_wdata  = pwdata_in[15:0];
	assign link.irq_enable   = irq_en_q;

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_mux[7:0] = link.ctrl_rdata;
		end else if (hit_reload) begin
			rd_mux[15:0] = link.reload_rdata;
		end else if (hit_count) begin
			rd_mux[15:0] = link.count_rdata;
		end else if (hit_irq_en) begin
			rd_mux[0] = irq_en_q;
		end
	end

	// Read data is sampled in the setup cycle so the slave never waits.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prdata_q <= 32'h0000_0000;
			irq_en_q <= 1'b0;
		end else begin
			if (setup_phase) begin
				prdata_q <= rd_mux;
			end
			if (wr_access & hit_irq_en) begin
				irq_en_q <= pwdata_in[0];
			end
		end
	end

	assign prdata_out  = prdata_q;
	assign pready_out  = 1'b1;
	assign pslverr_out = access_phase & ~mapped;

endmodule

// ### bench/tbg_link_asserts.sv
// Concurrent checks on the link between the timer end and the register end.
`timescale 1ns/10ps
module tbg_link_asserts (
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire logic        ctrl_wr,
	input wire logic [7:0]  ctrl_wdata,
	input wire logic        reload_wr,
	input wire logic [15:0] reload_wdata,
	input wire logic        count_wr,
	input wire logic [15:0] count_wdata,
	input wire logic        irq_enable,
	input wire logic [7:0]  ctrl_rdata,
	input wire logic [15:0] reload_rdata,
	input wire logic [15:0] count_rdata,
	input wire logic        timer1_overflow_in,
	input wire logic        overflow_pulse_out,
	input wire logic        tx_bit_clock_out,
	input wire logic        rx_bit_clock_out,
	input wire logic        timer_irq_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	// ----------------------------------------------------------------
	// Source of each bit clock, one cycle late to match the pulse.
	// ----------------------------------------------------------------
	logic tx_src_q;
	logic rx_src_q;
	wire  baud = ctrl_rdata[5] | ctrl_rdata[4];

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tx_src_q <= 1'b0;
			rx_src_q <= 1'b0;
		end else begin
			tx_src_q <= ctrl_rdata[4] ? overflow_pulse_out : timer1_overflow_in;
			rx_src_q <= ctrl_rdata[5] ? overflow_pulse_out : timer1_overflow_in;
		end
	end

	// ----------------------------------------------------------------
	// Assertions.
	// ----------------------------------------------------------------
	a_tx_source_pick: assert property (tx_bit_clock_out |-> tx_src_q) else $error("tx bit clock without source pulse");
	a_rx_source_pick: assert property (rx_bit_clock_out |-> rx_src_q) else $error("rx bit clock without source pulse");
	a_tx_bit_gap: assert property (tx_bit_clock_out |=> !tx_bit_clock_out [*8]) else $error("tx bit clocks too close");
	a_rx_bit_gap: assert property (rx_bit_clock_out |=> !rx_bit_clock_out [*8]) else $error("rx bit clocks too close");
	// The pulse trails the rollover by one cycle, so the counter then holds what the reload held at the rollover.
	a_rollover_reload: assert property (overflow_pulse_out && !$past(count_wr) |->
		count_rdata == $past(reload_rdata) && $past(count_rdata) == 16'hffff)
		else $error("rollover did not load reload value");
	a_trigger_no_reload: assert property (baud && $past(baud) && !$past(count_wr) |->
		count_rdata == $past(count_rdata) || count_rdata == $past(count_rdata) + 16'h0001
		|| ($past(count_rdata) == 16'hffff && count_rdata == $past(reload_rdata)))
		else $error("baud counter moved other than by tick or rollover");
	a_single_pulse: assert property (overflow_pulse_out |=> !overflow_pulse_out) else $error("overflow pulse too long");
	a_pulse_only_baud: assert property (!baud [*3] |-> !overflow_pulse_out) else $error("overflow pulse outside baud mode");
	a_baud_no_flag: assert property (baud && !ctrl_rdata[7] && !ctrl_wr |=> !ctrl_rdata[7]) else $error("baud rollover set flag");
	a_irq_follows: assert property ((irq_enable && (ctrl_rdata[7] || ctrl_rdata[6])) [*2] |-> timer_irq_out)
		else $error("interrupt missing with flag set");
	a_irq_masked: assert property (!irq_enable [*2] |-> !timer_irq_out) else $error("interrupt while disabled");
	a_ctrl_lands: assert property (ctrl_wr |=> ctrl_rdata[5:0] == $past(ctrl_wdata[5:0])) else $error("control write lost");
	a_count_lands: assert property (count_wr |=> count_rdata == $past(count_wdata)) else $error("count write lost");
	a_reload_lands: assert property (reload_wr && (baud || !ctrl_rdata[0]) |=> reload_rdata == $past(reload_wdata))
		else $error("reload write lost");

	c_overflow: cover property (overflow_pulse_out);
	c_tx_timer1: cover property (tx_bit_clock_out && !ctrl_rdata[4]);
	c_irq: cover property (timer_irq_out);
endmodule

// ### bench/timer2_baud_rate_generator_tb.sv
// Self-checking bench for the timer end joined to its APB register end.
`timescale 1ns/10ps
module timer2_baud_rate_generator_tb;
	import tbg_pkg::*;

	logic        clk_in, rst_b_in, psel, pen, pwr, trig, ext_run, re;
	logic        t1ov = 1'b0;
	logic        ext_pin = 1'b1;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        pready, pslverr, ovf, txb, rxb, irq;
	logic [15:0] rl;
	logic [7:0]  codes [3];
	int          bad_count, checked, cyc, t1c, n;
	int          lt [3];
	int          gp [3];
	wire  [2:0]  pv = {rxb, txb, ovf};

	tbg_link_if link_i();
	tbg_timer_end tbg_timer_end_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link_i),
		.external_count_pin_in(ext_pin), .trigger_input_pin_in(trig), .timer1_overflow_in(t1ov),
		.overflow_pulse_out(ovf), .tx_bit_clock_out(txb), .rx_bit_clock_out(rxb), .timer_irq_out(irq));
	tbg_apb_end tbg_apb_end_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .link(link_i));
	tbg_link_asserts tbg_link_asserts_i(.clk_in(clk_in), .rst_b_in(rst_b_in), .ctrl_wr(link_i.ctrl_wr),
		.ctrl_wdata(link_i.ctrl_wdata), .reload_wr(link_i.reload_wr), .reload_wdata(link_i.reload_wdata),
		.count_wr(link_i.count_wr), .count_wdata(link_i.count_wdata), .irq_enable(link_i.irq_enable),
		.ctrl_rdata(link_i.ctrl_rdata), .reload_rdata(link_i.reload_rdata), .count_rdata(link_i.count_rdata),
		.timer1_overflow_in(t1ov), .overflow_pulse_out(ovf), .tx_bit_clock_out(txb),
		.rx_bit_clock_out(rxb), .timer_irq_out(irq));

	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end

	// ----------------------------------------------------------------
	// First timer pulses every 20 cycles, count pin and pulse spacing.
	// ----------------------------------------------------------------
	always @(posedge clk_in) begin
		cyc++;
		t1c = (t1c == 19) ? 0 : t1c + 1;
		t1ov <= (t1c == 0);
		if (ext_run && cyc % 4 == 0) ext_pin <= ~ext_pin;
		for (int i = 0; i < 3; i++) if (pv[i] === 1'b1) begin
			gp[i] = cyc - lt[i];
			lt[i] = cyc;
		end
	end

	// Only the watchdog ends a wait for the slave's answer.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
		@(posedge clk_in);
		pen <= 1'b1;
		do begin
			@(posedge clk_in);
		end while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0; pen <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rv, e);
	endtask

	task automatic print_verdict;
		$display("checked=%0d bad_count=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	// The longest test waits 1800 cycles; the whole run needs under 9000.
	initial begin
		repeat (20000) @(posedge clk_in);
		bad_count++;
		print_verdict;
	end

	initial begin
		{rst_b_in, psel, pen, pwr, ext_run} = 5'h00;
		trig = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		codes = '{SETUP_BAUD_BOTH_INT, SETUP_BAUD_RX_INT, SETUP_BAUD_TX_INT};
		rv = $urandom(32'h54ff);
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		for (n = 0; n < 4; n++) rd(8'(n * 4), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(rv, 32'h0);
		chk({31'h0, re}, 32'h1);
		$display("test reset done");
		apb(1'b1, OFS_IRQ_ENABLE, 32'h1);
		for (n = 0; n < 3; n++) begin
			rl = 16'hfff0 + 16'($urandom % 15);
			apb(1'b1, OFS_CONTROL, 32'h0);
			apb(1'b1, OFS_RELOAD, {16'h0, rl});
			// Start from the reload value so the first rollover comes within the wait.
			apb(1'b1, OFS_COUNT, {16'h0, rl});
			apb(1'b1, OFS_CONTROL, {24'h0, codes[n]});
			gp = '{0, 0, 0};
			repeat (1800) @(posedge clk_in);
			chk(gp[0], 2 * (65536 - rl));
			chk(gp[1], codes[n][4] ? 32 * (65536 - rl) : 320);
			chk(gp[2], codes[n][5] ? 32 * (65536 - rl) : 320);
			rd(OFS_CONTROL, {24'h0, codes[n]});
			rd(OFS_RELOAD, {16'h0, rl});
			chk({31'h0, irq}, 32'h0);
			$display("test baud code %h done", codes[n]);
		end
		apb(1'b1, OFS_CONTROL, 32'h3c);
		trig <= 1'b0;
		repeat (10) @(posedge clk_in);
		trig <= 1'b1;
		repeat (10) @(posedge clk_in);
		rd(OFS_CONTROL, 32'h7c);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, OFS_CONTROL, 32'h3c);
		rd(OFS_CONTROL, 32'h3c);
		chk({31'h0, irq}, 32'h0);
		$display("test trigger done");
		apb(1'b1, OFS_CONTROL, 32'h0);
		apb(1'b1, OFS_RELOAD, 32'hfffc);
		apb(1'b1, OFS_CONTROL, {24'h0, SETUP_BAUD_BOTH_EXT});
		ext_run <= 1'b1;
		gp = '{0, 0, 0};
		repeat (1800) @(posedge clk_in);
		chk(gp[0], 32);
		chk(gp[1], 512);
		ext_run <= 1'b0;
		$display("test count pin done");
		apb(1'b1, OFS_CONTROL, 32'h0);
		apb(1'b1, OFS_COUNT, 32'h0);
		apb(1'b1, OFS_CONTROL, 32'h04);
		repeat (240) @(posedge clk_in);
		apb(1'b1, OFS_CONTROL, 32'h0);
		apb(1'b0, OFS_COUNT, 32'h0);
		chk({31'h0, rv >= 19 && rv <= 21}, 32'h1);
		apb(1'b1, OFS_RELOAD, 32'hfff0);
		apb(1'b1, OFS_COUNT, 32'hfffe);
		apb(1'b1, OFS_CONTROL, 32'h04);
		repeat (40) @(posedge clk_in);
		rd(OFS_CONTROL, 32'h84);
		chk({31'h0, irq}, 32'h1);
		$display("test auto reload done");
		// Counter mode with a still count pin, so the captured value is exact.
		apb(1'b1, OFS_CONTROL, 32'h0);
		apb(1'b1, OFS_COUNT, 32'h1234);
		apb(1'b1, OFS_RELOAD, 32'h0);
		apb(1'b1, OFS_CONTROL, {24'h0, SETUP_CNT_CAPTURE_EXT | 8'h04});
		trig <= 1'b0;
		repeat (10) @(posedge clk_in);
		trig <= 1'b1;
		repeat (10) @(posedge clk_in);
		rd(OFS_CONTROL, {24'h0, SETUP_CNT_CAPTURE_EXT | 8'h44});
		rd(OFS_RELOAD, 32'h1234);
		chk({31'h0, irq}, 32'h1);
		$display("test capture done");
		print_verdict;
	end
endmodule
